// File: rtl/clock_select_pkg.sv
package clock_select_pkg;
  localparam logic [7:0] CLOCK_SOURCE_SELECT_ADDR  = 8'hA9;
  localparam logic [7:0] CLOCK_SOURCE_SELECT_RESET = 8'h00;
  localparam logic [7:0] CLOCK_SOURCE_SELECT_MASK  = 8'h37;
  localparam int         SYSCLK_FIELD_LSB          = 0;
  localparam int         SYSCLK_FIELD_W            = 3;
  localparam int         USB_CLOCK_SOURCE_FIELD_FIELD_LSB          = 4;
  localparam int         USB_CLOCK_SOURCE_FIELD_FIELD_W            = 2;
  localparam logic [2:0] SYS_SRC_HF_OSC            = 3'h0;
  localparam logic [2:0] SYS_SRC_EXT_CLK           = 3'h1;
  localparam logic [2:0] SYS_SRC_MUL_HALF          = 3'h2;
  localparam logic [2:0] SYS_SRC_LF_OSC            = 3'h3;
  localparam logic [1:0] USB_SRC_MUL               = 2'h0;
  localparam logic [1:0] USB_SRC_HF_HALF           = 2'h1;
  localparam logic [1:0] USB_SRC_EXT_CLK           = 2'h2;
  localparam logic [1:0] USB_SRC_OFF               = 2'h3;
endpackage

// File: rtl/clock_halver.sv
`timescale 1ns/1ps
// Turns a synchronised level clock into half rate level
module clock_halver
(
  input  wire logic i_clk,
  input  wire logic i_reset,
  input  wire logic i_src,
  output logic      o_half
);
  logic src_q;

  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      src_q  <= 1'b0;
      o_half <= 1'b0;
    end
    else
    begin
      src_q <= i_src;
      if (i_src && !src_q)
        o_half <= ~o_half;
    end
  end
endmodule // clock_halver

// File: rtl/system_usb_clock_select.sv
`timescale 1ns/1ps
module system_usb_clock_select
  import clock_select_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  input  wire logic [7:0] i_sfr_addr,
  input  wire logic       i_sfr_wr,
  input  wire logic [7:0] i_sfr_wdata,
  output logic      [7:0] o_sfr_rdata,
  input  wire logic       i_hf_osc,
  input  wire logic       i_ext_clk,
  input  wire logic       i_mul_clk,
  input  wire logic       i_lf_osc,
  output logic            o_sysclk,
  output logic            o_usb_clock_source_field,
  output logic            o_periph_ext_clk
);
  logic [7:0] clock_source_select;
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic       hf_half;
  logic       mul_half;
  logic [2:0] sysclk_source_field;
  logic [1:0] usb_clock_source_field;
  logic       next_sysclk;
  logic       next_usb_clock_source_field;

  assign sysclk_source_field    = clock_source_select[SYSCLK_FIELD_LSB +: SYSCLK_FIELD_W];
  assign usb_clock_source_field = clock_source_select[USB_CLOCK_SOURCE_FIELD_FIELD_LSB +: USB_CLOCK_SOURCE_FIELD_FIELD_W];

  // Register write; unused bits never stored
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
      clock_source_select <= CLOCK_SOURCE_SELECT_RESET;
    else if (i_sfr_wr && i_sfr_addr == CLOCK_SOURCE_SELECT_ADDR)
      clock_source_select <= i_sfr_wdata & CLOCK_SOURCE_SELECT_MASK;
  end

  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
      o_sfr_rdata <= 8'h00;
    else if (i_sfr_addr == CLOCK_SOURCE_SELECT_ADDR)
      o_sfr_rdata <= clock_source_select;
    else
      o_sfr_rdata <= 8'h00;
  end

  // Two-stage synchronisers for the source clocks
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
    end
    else
    begin
      sync1 <= {i_lf_osc, i_mul_clk, i_ext_clk, i_hf_osc};
      sync2 <= sync1;
    end
  end

  // HF oscillator halved for the low-speed USB path
  clock_halver u_hf_half
  (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_src   (sync2[0]),
    .o_half  (hf_half)
  );

  // Multiplier output (48 MHz from 12 MHz upstream) halved
  clock_halver u_mul_half
  (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_src   (sync2[2]),
    .o_half  (mul_half)
  );

  // No wait state: HF source is usable at once, switching is free
  always_comb
  begin
    case (sysclk_source_field)
      SYS_SRC_HF_OSC:   next_sysclk = sync2[0];
      SYS_SRC_EXT_CLK:  next_sysclk = sync2[1];
      SYS_SRC_MUL_HALF: next_sysclk = mul_half;
      SYS_SRC_LF_OSC:   next_sysclk = sync2[3];
      default:          next_sysclk = sync2[0];
    endcase
  end

  always_comb
  begin
    case (usb_clock_source_field)
      USB_SRC_MUL:     next_usb_clock_source_field = sync2[2];
      USB_SRC_HF_HALF: next_usb_clock_source_field = hf_half;
      USB_SRC_EXT_CLK: next_usb_clock_source_field = sync2[1];
      USB_SRC_OFF:     next_usb_clock_source_field = 1'b0;
      default:         next_usb_clock_source_field = 1'b0;
    endcase
  end

  // System clock output flop
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
      o_sysclk <= 1'b0;
    else
      o_sysclk <= next_sysclk;
  end

  // USB clock output flop; low while the USB field is off
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
      o_usb_clock_source_field <= 1'b0;
    else
      o_usb_clock_source_field <= next_usb_clock_source_field;
  end

  // External clock forwarded to peripherals whatever the system source
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
      o_periph_ext_clk <= 1'b0;
    else
      o_periph_ext_clk <= sync2[1];
  end

  // Write request aimed at the select register
  sequence reg_write_s;
    i_sfr_wr && (i_sfr_addr == CLOCK_SOURCE_SELECT_ADDR);
  endsequence

  // Select register addressed for a read
  sequence reg_read_s;
    i_sfr_addr == CLOCK_SOURCE_SELECT_ADDR;
  endsequence

  // USB field parked at the off code for two edges
  sequence usb_off_s;
    (usb_clock_source_field == USB_SRC_OFF) [*2];
  endsequence

  AST_SYS_EXT: assert property (@(posedge i_clk) disable iff (i_reset)
    (sysclk_source_field == SYS_SRC_EXT_CLK) |=> (o_sysclk == $past(sync2[1])))
    else $error("system clock not following external clock");
  AST_SYS_HF: assert property (@(posedge i_clk) disable iff (i_reset)
    (sysclk_source_field == SYS_SRC_HF_OSC) |=> (o_sysclk == $past(sync2[0])))
    else $error("system clock not following HF oscillator");
  AST_SYS_LF: assert property (@(posedge i_clk) disable iff (i_reset)
    (sysclk_source_field == SYS_SRC_LF_OSC) |=> (o_sysclk == $past(sync2[3])))
    else $error("system clock not following LF oscillator");
  AST_SYS_MUL: assert property (@(posedge i_clk) disable iff (i_reset)
    (sysclk_source_field == SYS_SRC_MUL_HALF) |=> (o_sysclk == $past(mul_half)))
    else $error("system clock not following halved multiplier");
  AST_PERIPH_EXT: assert property (@(posedge i_clk) disable iff (i_reset)
    1'b1 |=> (o_periph_ext_clk == $past(sync2[1])))
    else $error("peripheral external clock lost");
  AST_USB_OFF: assert property (@(posedge i_clk) disable iff (i_reset)
    usb_off_s |-> !o_usb_clock_source_field)
    else $error("USB clock running while off");
  AST_USB_MUL: assert property (@(posedge i_clk) disable iff (i_reset)
    (usb_clock_source_field == USB_SRC_MUL) |=> (o_usb_clock_source_field == $past(sync2[2])))
    else $error("USB clock not following multiplier");
  AST_UNUSED_ZERO: assert property (@(posedge i_clk) disable iff (i_reset)
    (clock_source_select & ~CLOCK_SOURCE_SELECT_MASK) == 8'h00)
    else $error("unused select bits set");

  // Register bus checks
  AST_REG_WRITE: assert property (@(posedge i_clk) disable iff (i_reset)
    reg_write_s |=> (clock_source_select == ($past(i_sfr_wdata) & CLOCK_SOURCE_SELECT_MASK)))
    else $error("select register write lost");
  AST_REG_HOLD: assert property (@(posedge i_clk) disable iff (i_reset)
    !(i_sfr_wr && (i_sfr_addr == CLOCK_SOURCE_SELECT_ADDR)) |=> $stable(clock_source_select))
    else $error("select register changed without a write");
  AST_RDATA: assert property (@(posedge i_clk) disable iff (i_reset)
    reg_read_s |=> (o_sfr_rdata == $past(clock_source_select)))
    else $error("read data differs from select register");
  AST_RDATA_OTHER: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_sfr_addr != CLOCK_SOURCE_SELECT_ADDR) |=> (o_sfr_rdata == 8'h00))
    else $error("read data not zero for other address");

  // Remaining source codes
  AST_USB_HF_HALF: assert property (@(posedge i_clk) disable iff (i_reset)
    (usb_clock_source_field == USB_SRC_HF_HALF) |=> (o_usb_clock_source_field == $past(hf_half)))
    else $error("USB clock not following halved HF oscillator");
  AST_USB_EXT: assert property (@(posedge i_clk) disable iff (i_reset)
    (usb_clock_source_field == USB_SRC_EXT_CLK) |=> (o_usb_clock_source_field == $past(sync2[1])))
    else $error("USB clock not following external clock");
  AST_SYS_FALLBACK: assert property (@(posedge i_clk) disable iff (i_reset)
    sysclk_source_field[2] |=> (o_sysclk == $past(sync2[0])))
    else $error("unused system code not on HF oscillator");

  // Halved multiplier moves only on a rising synchronised edge
  AST_MUL_HALF_TOGGLE: assert property (@(posedge i_clk) disable iff (i_reset)
    (sync2[2] && !$past(sync2[2])) |=> (mul_half != $past(mul_half)))
    else $error("halved multiplier missed a rising edge");
  AST_MUL_HALF_HOLD: assert property (@(posedge i_clk) disable iff (i_reset)
    !(sync2[2] && !$past(sync2[2])) |=> $stable(mul_half))
    else $error("halved multiplier moved without a rising edge");
endmodule // system_usb_clock_select

// File: test/clock_sources.sv
`timescale 1ns/1ps
// Free-running sources, always enabled and stable
module clock_sources
(
  input  wire logic i_clk,
  output logic      o_hf,
  output logic      o_ext,
  output logic      o_mul,
  output logic      o_lf
);
  int n = 0;
  always @(negedge i_clk)
  begin
    n <= n + 1;
    o_hf <= n % 4 < 2;
    o_ext <= n % 6 < 3;
    o_mul <= n % 10 < 5;
    o_lf <= n % 14 < 7;
  end
endmodule // clock_sources

// File: test/system_usb_clock_select_test.sv
`timescale 1ns/1ps
module system_usb_clock_select_test;
  import clock_select_pkg::*;
  localparam logic [7:0] A = CLOCK_SOURCE_SELECT_ADDR;
  logic       i_clk = 0;
  logic       i_reset = 1;
  logic [7:0] addr = 0;
  logic       wr = 0;
  logic [7:0] wd = 0;
  logic [7:0] rd;
  logic       hf, ext, mul, lf, sys, usb, pext;
  logic [3:0] h0, h1, h2;
  logic       mt, ht, mq, hq, es, eu;
  logic [7:0] r = 0;
  logic [7:0] q[$];
  bit         en = 0;
  int         errors = 0;
  int         total_checks = 0;
  int         seed = 32'h8210;
  clock_sources src_u (.i_clk(i_clk), .o_hf(hf), .o_ext(ext), .o_mul(mul), .o_lf(lf));
  system_usb_clock_select dut_u (.i_clk(i_clk), .i_reset(i_reset), .i_sfr_addr(addr),
    .i_sfr_wr(wr), .i_sfr_wdata(wd), .o_sfr_rdata(rd), .i_hf_osc(hf), .i_ext_clk(ext),
    .i_mul_clk(mul), .i_lf_osc(lf), .o_sysclk(sys), .o_usb_clock_source_field(usb), .o_periph_ext_clk(pext));
  initial forever #12.5 i_clk = ~i_clk;
  // Source samples, aged to match the three-edge output latency; halved
  // sources toggle on each sampled rising edge and show one edge later
  always @(posedge i_clk)
    if (i_reset)
      {mt, ht, mq, hq, h2, h1, h0} <= '0;
    else
    begin
      {h2, h1, h0} <= {h1, h0, lf, mul, ext, hf};
      mt <= mt ^ (h1[2] & ~h2[2]);
      ht <= ht ^ (h1[0] & ~h2[0]);
      {mq, hq} <= {mt, ht};
    end
  task chk(string s, logic [7:0] x, logic [7:0] y);
    total_checks++;
    if (x !== y)
    begin
      errors++;
      $display("Error %s expected %h seen %h", s, x, y);
    end
  endtask
  always @(posedge i_clk)
    if (q.size() > 0)
    begin
      #1;
      chk("rdata", q.pop_front(), rd);
    end
  always @(negedge i_clk)
    if (en)
    begin
      case (r[2:0])
        SYS_SRC_EXT_CLK:  es = h2[1];
        SYS_SRC_MUL_HALF: es = mq;
        SYS_SRC_LF_OSC:   es = h2[3];
        default:          es = h2[0];
      endcase
      case (r[5:4])
        USB_SRC_MUL:     eu = h2[2];
        USB_SRC_HF_HALF: eu = hq;
        USB_SRC_EXT_CLK: eu = h2[1];
        default:         eu = 1'b0;
      endcase
      chk("periph", 8'(h2[1]), 8'(pext));
      chk("sys", 8'(es), 8'(sys));
      chk("usb", 8'(eu), 8'(usb));
    end
  task wr_reg(logic [7:0] a, logic [7:0] d);
    @(negedge i_clk);
    addr = a;
    wr = 1;
    wd = d;
    if (a == A)
      r = d & CLOCK_SOURCE_SELECT_MASK;
    @(negedge i_clk);
    wr = 0;
    q.push_back(a == A ? r : 8'h00);
    @(negedge i_clk);
    addr = A;
    q.push_back(r);
    @(negedge i_clk);
    en = 1;
    repeat (12) @(negedge i_clk);
    en = 0;
  endtask
  task tally_and_finish;
    $display("Checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(negedge i_clk);
    chk("reset rdata", 8'h00, rd);
    chk("reset clocks", 8'h00, {5'h00, sys, usb, pext});
    i_reset = 0;
    wr_reg(8'h00, 8'h00);
    wr_reg(A, {2'h0, USB_SRC_MUL, 1'b0, SYS_SRC_HF_OSC});
    wr_reg(A, {2'h0, USB_SRC_EXT_CLK, 1'b0, SYS_SRC_EXT_CLK});
    wr_reg(A, {2'h0, USB_SRC_HF_HALF, 1'b0, SYS_SRC_LF_OSC});
    for (int i = 0; i < 8; i++)
      wr_reg(A, {2'($random(seed)), i[1:0], 1'($random(seed)), i[2:0]});
    wr_reg(A, 8'hFF);
    for (int i = 0; i < 12; i++)
      wr_reg(i[0] ? A : 8'($random(seed)), 8'($random(seed)));
    @(negedge i_clk);
    i_reset = 1;
    r = CLOCK_SOURCE_SELECT_RESET;
    @(negedge i_clk);
    chk("midreset rdata", 8'h00, rd);
    chk("midreset clocks", 8'h00, {5'h00, sys, usb, pext});
    i_reset = 0;
    wr_reg(8'h00, 8'h00);
    tally_and_finish();
  end
endmodule // system_usb_clock_select_test
